// ==== pjs_sequencer.sv ====
// Function
// - Start needs writable, power, no alarm, no safe state, off
// - Alternate pattern A and B until stopped
// - Turns signed -50..50, default 5
// - Peak speed 100..3000 rpm, default 1000
// - One ramp time for accel and decel
// - Dwell after each move, 100..10000 ms
// - Short moves finish without reaching peak
// - Run begins with pattern A direction
// - Travel limits ignored while jogging
// - Stop request or session close ends sequence
//
// Purpose: Program jog profile sequencer with APB register access.
// Assumes: Speed integrated once per ms; position in 1/65536 turn.
// Notes:   Out-of-range writes are clamped to the nearest limit.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module pjs_sequencer
    import pjs_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Drive conditions
    input  wire logic        params_writable,
    input  wire logic        main_power_on,
    input  wire logic        alarm_active,
    input  wire logic        safe_state,
    input  wire logic        servo_on,
    input  wire logic        forward_travel_limit,
    input  wire logic        reverse_travel_limit,
    input  wire logic        session_closed,
    // Motion command
    output logic             jog_active,
    output logic             limit_override,
    output logic [11:0]      speed_cmd,
    output logic             dir_reverse,
    output logic [23:0]      pos_cmd
);
    // ****************************************
    // Types and helpers
    // ****************************************
    typedef enum logic [4:0] {
        PJS_IDLE  = 5'b00001,
        PJS_ACCEL = 5'b00010,
        PJS_CRUIS = 5'b00100,
        PJS_DECEL = 5'b01000,
        PJS_DWELL = 5'b10000
    } pjs_state_e;

    function automatic logic [31:0] clamp(input logic [31:0] v, input int lo, input int hi);
        if ($signed(v) < lo) return 32'(lo);
        if ($signed(v) > hi) return 32'(hi);
        return v;
    endfunction

    // Speed gain per ms in rpm, rounded up so the ramp ends in time.
    function automatic logic [11:0] step_of(input logic [11:0] pk, input logic [10:0] rt);
        return 12'((32'(pk) + 32'(rt) - 32'h1) / 32'(rt));
    endfunction

    // Distance per ms in position units: rpm * 65536 / 60000.
    function automatic logic [23:0] dist_of(input logic [11:0] sp);
        return 24'((32'(sp) * 32'h10000) / 32'd60000);
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic signed [7:0] turns_reg [2];
    logic [11:0]       speed_reg [2];
    logic [10:0]       ramp_reg  [2];
    logic [13:0]       dwell_reg [2];
    logic signed [7:0] turns_next [2];
    logic [11:0]       speed_next [2];
    logic [10:0]       ramp_next  [2];
    logic [13:0]       dwell_next [2];
    pjs_state_e        st_reg, st_next;
    logic              pat_reg, pat_next;
    logic              peak_reg, peak_next;
    logic [11:0]       spd_reg, spd_next;
    logic [23:0]       done_reg, done_next;
    logic [23:0]       pos_reg, pos_next;
    logic [13:0]       ms_reg, ms_next;
    logic [31:0]       rdata_reg, rdata_next;
    logic              tick;
    logic              wr, rd, start_ok;
    logic [23:0]       target, remain, brake, mv;
    logic [11:0]       step;
    logic [31:0]       wv;
    int unsigned       idx;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign wv = pwdata;

    assign start_ok = params_writable && main_power_on && !alarm_active
                      && !safe_state && !servo_on
                      && !forward_travel_limit && !reverse_travel_limit;

    pjs_ms_tick #(
        .TICK_CYCLES(MS_CYCLES)
    ) u_tick (
        .pclk   (pclk),
        .presetn(presetn),
        .enable (st_reg != PJS_IDLE),
        .tick   (tick)
    );

    // ****************************************
    // Register file
    // ****************************************
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            turns_next[p] = turns_reg[p];
            speed_next[p] = speed_reg[p];
            ramp_next[p]  = ramp_reg[p];
            dwell_next[p] = dwell_reg[p];
        end
        idx = (paddr >= PJS_B_TURNS_OFS) ? 1 : 0;
        if (wr) begin
            unique case (paddr)
                PJS_A_TURNS_OFS, PJS_B_TURNS_OFS:
                    turns_next[idx] = 8'(clamp(wv, TURNS_MIN, TURNS_MAX));
                PJS_A_SPEED_OFS, PJS_B_SPEED_OFS:
                    speed_next[idx] = 12'(clamp(wv, SPEED_MIN, SPEED_MAX));
                PJS_A_RAMP_OFS, PJS_B_RAMP_OFS:
                    ramp_next[idx] = 11'(clamp(wv, RAMP_MIN, RAMP_MAX));
                PJS_A_DWELL_OFS, PJS_B_DWELL_OFS:
                    dwell_next[idx] = 14'(clamp(wv, DWELL_MIN, DWELL_MAX));
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_next = rdata_reg;
        if (rd) begin
            unique case (paddr)
                PJS_STAT_OFS: rdata_next = {27'h0, peak_reg, st_reg == PJS_ACCEL
                    || st_reg == PJS_CRUIS || st_reg == PJS_DECEL,
                    st_reg == PJS_DWELL, pat_reg, st_reg != PJS_IDLE};
                PJS_COND_OFS: rdata_next = {31'h0, start_ok};
                PJS_A_TURNS_OFS: rdata_next = 32'(turns_reg[0]);
                PJS_A_SPEED_OFS: rdata_next = {20'h0, speed_reg[0]};
                PJS_A_RAMP_OFS:  rdata_next = {21'h0, ramp_reg[0]};
                PJS_A_DWELL_OFS: rdata_next = {18'h0, dwell_reg[0]};
                PJS_B_TURNS_OFS: rdata_next = 32'(turns_reg[1]);
                PJS_B_SPEED_OFS: rdata_next = {20'h0, speed_reg[1]};
                PJS_B_RAMP_OFS:  rdata_next = {21'h0, ramp_reg[1]};
                PJS_B_DWELL_OFS: rdata_next = {18'h0, dwell_reg[1]};
                default:         rdata_next = 32'h0;
            endcase
        end
    end

    assign pready  = 1'b1;
    assign prdata  = rdata_reg;
    assign pslverr = psel && penable && !(paddr inside {PJS_CTRL_OFS, PJS_STAT_OFS,
        PJS_COND_OFS, PJS_A_TURNS_OFS, PJS_A_SPEED_OFS, PJS_A_RAMP_OFS, PJS_A_DWELL_OFS,
        PJS_B_TURNS_OFS, PJS_B_SPEED_OFS, PJS_B_RAMP_OFS, PJS_B_DWELL_OFS});

    // ****************************************
    // Profile sequencer
    // ****************************************
    assign target = {8'(turns_reg[pat_reg] < 0 ? -turns_reg[pat_reg] : turns_reg[pat_reg]),
                     16'h0};
    assign remain = target - done_reg;
    assign step   = step_of(speed_reg[pat_reg], ramp_reg[pat_reg]);
    // Distance needed to brake from the present speed with the ramp step.
    assign brake  = 24'((32'(dist_of(spd_reg)) * (32'(spd_reg / step) + 32'h1)) >> 1);
    // Last step clipped so the move ends on its exact turn count
    assign mv     = (dist_of(spd_reg) >= remain) ? remain : dist_of(spd_reg);

    always_comb begin
        st_next   = st_reg;
        pat_next  = pat_reg;
        peak_next = peak_reg;
        spd_next  = spd_reg;
        done_next = done_reg;
        pos_next  = pos_reg;
        ms_next   = ms_reg;
        unique case (st_reg)
            PJS_IDLE: begin
                if (wr && paddr == PJS_CTRL_OFS && wv[CTRL_RUN_BIT] && start_ok) begin
                    st_next   = PJS_ACCEL;
                    pat_next  = 1'b0;
                    peak_next = 1'b0;
                    spd_next  = 12'h0;
                    done_next = 24'h0;
                end
            end
            PJS_ACCEL, PJS_CRUIS, PJS_DECEL: begin
                if (tick) begin
                    done_next = done_reg + mv;
                    pos_next  = turns_reg[pat_reg] < 0 ? pos_reg - mv : pos_reg + mv;
                    // begin braking once remaining distance demands it
                    if (st_reg != PJS_DECEL && remain <= brake) begin
                        st_next = PJS_DECEL;
                    // same step for accel and decel
                    end else if (st_reg == PJS_ACCEL) begin
                        if (spd_reg + step >= speed_reg[pat_reg]) begin
                            spd_next  = speed_reg[pat_reg];
                            peak_next = 1'b1;
                            st_next   = PJS_CRUIS;
                        end else begin
                            spd_next = spd_reg + step;
                        end
                    end else if (st_reg == PJS_DECEL) begin
                        spd_next = (spd_reg > step) ? spd_reg - step : 12'h1;
                    end
                    if (done_next == target || target == 24'h0) begin
                        spd_next = 12'h0;
                        st_next  = PJS_DWELL;
                        ms_next  = 14'h0;
                    end
                end
            end
            PJS_DWELL: begin
                // hold still for the dwell time
                if (tick) begin
                    ms_next = ms_reg + 14'h1;
                    if (ms_reg + 14'h1 >= dwell_reg[pat_reg]) begin
                        pat_next  = ~pat_reg;
                        st_next   = PJS_ACCEL;
                        peak_next = 1'b0;
                        done_next = 24'h0;
                    end
                end
            end
            default: st_next = PJS_IDLE;
        endcase
        // stop or session close ends jogging
        if (st_reg != PJS_IDLE && (session_closed
            || (wr && paddr == PJS_CTRL_OFS && wv[CTRL_STOP_BIT]))) begin
            st_next  = PJS_IDLE;
            spd_next = 12'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < 2; p++) begin
                turns_reg[p] <= 8'(TURNS_DEF);
                speed_reg[p] <= 12'(SPEED_DEF);
                ramp_reg[p]  <= 11'(RAMP_DEF);
                dwell_reg[p] <= 14'(DWELL_DEF);
            end
            st_reg    <= PJS_IDLE;
            pat_reg   <= 1'b0;
            peak_reg  <= 1'b0;
            spd_reg   <= 12'h0;
            done_reg  <= 24'h0;
            pos_reg   <= 24'h0;
            ms_reg    <= 14'h0;
            rdata_reg <= 32'h0;
        end else begin
            turns_reg <= turns_next;
            speed_reg <= speed_next;
            ramp_reg  <= ramp_next;
            dwell_reg <= dwell_next;
            st_reg    <= st_next;
            pat_reg   <= pat_next;
            peak_reg  <= peak_next;
            spd_reg   <= spd_next;
            done_reg  <= done_next;
            pos_reg   <= pos_next;
            ms_reg    <= ms_next;
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign jog_active     = st_reg != PJS_IDLE;
    assign limit_override = st_reg != PJS_IDLE;
    assign speed_cmd      = spd_reg;
    assign dir_reverse    = turns_reg[pat_reg] < 0;
    assign pos_cmd        = pos_reg;
endmodule : pjs_sequencer

// ==== pjs_pkg.sv ====
// Purpose: Shared constants for the program jog profile sequencer.
// Assumes: 32-bit APB register bus, pclk at 250 MHz.
// Notes:   Register offsets are byte addresses of aligned words.
package pjs_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] PJS_CTRL_OFS    = 8'h00;
    localparam logic [7:0] PJS_STAT_OFS    = 8'h04;
    localparam logic [7:0] PJS_COND_OFS    = 8'h08;
    localparam logic [7:0] PJS_A_TURNS_OFS = 8'h10;
    localparam logic [7:0] PJS_A_SPEED_OFS = 8'h14;
    localparam logic [7:0] PJS_A_RAMP_OFS  = 8'h18;
    localparam logic [7:0] PJS_A_DWELL_OFS = 8'h1c;
    localparam logic [7:0] PJS_B_TURNS_OFS = 8'h20;
    localparam logic [7:0] PJS_B_SPEED_OFS = 8'h24;
    localparam logic [7:0] PJS_B_RAMP_OFS  = 8'h28;
    localparam logic [7:0] PJS_B_DWELL_OFS = 8'h2c;

    // ****************************************
    // Control and status bits
    // ****************************************
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_STOP_BIT  = 1;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_PAT_B_BIT = 1;
    localparam int STAT_DWELL_BIT = 2;
    localparam int STAT_MOVE_BIT  = 3;
    localparam int STAT_PEAK_BIT  = 4;

    // ****************************************
    // Setting ranges and reset values
    // ****************************************
    localparam int TURNS_MIN   = -50;
    localparam int TURNS_MAX   = 50;
    localparam int TURNS_DEF   = 5;
    localparam int SPEED_MIN   = 100;
    localparam int SPEED_MAX   = 3000;
    localparam int SPEED_DEF   = 1000;
    localparam int RAMP_MIN    = 50;
    localparam int RAMP_MAX    = 2000;
    localparam int RAMP_DEF    = 500;
    localparam int DWELL_MIN   = 100;
    localparam int DWELL_MAX   = 10000;
    localparam int DWELL_DEF   = 1000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ        = 250;
    localparam int MS_TIME        = 1;
    localparam int MS_CYCLES_DEF  = MS_TIME * CLK_MHZ * 1000;
    localparam int POS_FRAC_BITS  = 16;
    localparam int POS_TURN_BITS  = 8;
    localparam int POS_W          = POS_TURN_BITS + POS_FRAC_BITS;
    localparam int SPEED_W        = 12;
endpackage : pjs_pkg

// ==== pjs_ms_tick.sv ====
// Purpose: Millisecond tick generator for the profile sequencer.
// Assumes: Count fits 32 bits.
// Notes:   Runs only while enabled so each move starts on a full tick.
`timescale 1ns/1ps
module pjs_ms_tick #(
    parameter int TICK_CYCLES = 250000
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic enable,
    output logic      tick
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        tick     = 1'b0;
        if (!enable) begin
            cnt_next = 32'h0;
        end else if (cnt_reg == 32'(TICK_CYCLES - 1)) begin
            cnt_next = 32'h0;
            tick     = 1'b1;
        end else begin
            cnt_next = cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : pjs_ms_tick

// ==== pjs_motor_model.sv ====
// Purpose: Motor and machine model beside the jog sequencer.
// Assumes: Limit switches sit 0.75 turn either side of home.
// Notes:   Switches follow the commanded position only.
`timescale 1ns/1ps
module pjs_motor_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Command from the drive
    input  wire logic [23:0] pos_cmd,
    // Limit switches
    output logic             fwd_limit,
    output logic             rev_limit
);
    // ****************************************
    // Travel switches
    // ****************************************
    // switches trip mid-move
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_limit <= 1'b0;
            rev_limit <= 1'b0;
        end else begin
            fwd_limit <= $signed(pos_cmd) > $signed(24'h00c000);
            rev_limit <= $signed(pos_cmd) < $signed(24'hff4000);
        end
    end
endmodule // pjs_motor_model

// ==== pjs_sequencer_props.sv ====
// Purpose: Port checker for the jog sequencer.
// Assumes: One clock domain, settings from pjs_pkg.
// Notes:   Bound to every pjs_sequencer instance.
`timescale 1ns/1ps
module pjs_sequencer_props
    import pjs_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // Clock, reset, bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // Drive conditions
    input wire logic        params_writable,
    input wire logic        main_power_on,
    input wire logic        alarm_active,
    input wire logic        safe_state,
    input wire logic        servo_on,
    input wire logic        forward_travel_limit,
    input wire logic        reverse_travel_limit,
    input wire logic        session_closed,
    // Motion
    input wire logic        jog_active,
    input wire logic        limit_override,
    input wire logic [11:0] speed_cmd,
    input wire logic        dir_reverse,
    input wire logic [23:0] pos_cmd
);
    // Steepest legal ramp bounds each speed step
    localparam logic [11:0] STEP_MAX = 12'(SPEED_MAX / RAMP_MIN);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // Assertions
    // ****************************************
    a_start_when_ready:
        assert property ($rose(jog_active) |-> $past(params_writable && main_power_on
            && !alarm_active && !safe_state && !servo_on && !forward_travel_limit
            && !reverse_travel_limit)) else $error("jog started while not ready");
    a_idle_speed_zero:
        assert property (!jog_active |-> speed_cmd == 12'h000)
        else $error("speed commanded while idle");
    a_idle_pos_held:
        assert property ($past(!jog_active) && !jog_active |-> $stable(pos_cmd))
        else $error("position moved while idle");
    a_speed_in_range:
        assert property (speed_cmd <= 12'(SPEED_MAX)) else $error("speed above maximum");
    a_ramp_step_bound:
        assert property (jog_active && $past(jog_active) |->
            speed_cmd <= $past(speed_cmd) + STEP_MAX) else $error("speed step too large");
    a_dir_at_rest:
        assert property (jog_active && $changed(dir_reverse) |-> $past(speed_cmd) == 12'h000)
        else $error("direction changed while moving");
    a_override_follows_jog:
        assert property (limit_override == jog_active) else $error("override not jog state");
    a_session_ends_jog:
        assert property (session_closed |-> ##[0:2] (!jog_active && speed_cmd == 12'h000))
        else $error("session close did not stop");
    a_stop_ends_jog:
        assert property (psel && penable && pwrite && paddr == PJS_CTRL_OFS
            && pwdata[CTRL_STOP_BIT] |-> ##[1:2] !jog_active) else $error("stop ignored");
endmodule // pjs_sequencer_props

bind pjs_sequencer pjs_sequencer_props #(.MS_CYCLES(MS_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .params_writable(params_writable),
    .main_power_on(main_power_on), .alarm_active(alarm_active), .safe_state(safe_state),
    .servo_on(servo_on), .forward_travel_limit(forward_travel_limit),
    .reverse_travel_limit(reverse_travel_limit), .session_closed(session_closed),
    .jog_active(jog_active), .limit_override(limit_override), .speed_cmd(speed_cmd),
    .dir_reverse(dir_reverse), .pos_cmd(pos_cmd)
);

// ==== pjs_sequencer_test.sv ====
// Purpose: Self-checking bench for the jog profile sequencer.
// Assumes: MS_CYCLES of 10, so one ms is ten clocks.
// Notes:   Reads are judged by a bus monitor from a queue.
`timescale 1ns/1ps
module pjs_sequencer_test
    import pjs_pkg::*;
    ;
    localparam int          MS   = 10;
    localparam logic [32:0] FULL = '1;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic [6:0]  bad = 7'h00;
    logic        session_closed = 1'b0, saw_fwd = 1'b0;
    logic        pready, pslverr, jog_active, dir_reverse, fwd_lim, rev_lim, lim_ovr;
    logic        forward_travel_limit;
    logic [11:0] speed_cmd, peak_a = 12'h000, peak_b = 12'h000;
    logic [23:0] pos_cmd;
    logic [32:0] exp_q[$], msk_q[$], e, m;
    logic [15:0] rnd = 16'h0025;
    int          n_errors = 0, n_checks = 0, cyc = 0, zrun = 0, zmax = 0;
    logic [31:0] dflt[4] = '{32'(TURNS_DEF), 32'(SPEED_DEF), 32'(RAMP_DEF), 32'(DWELL_DEF)};
    logic [31:0] over[4] = '{-32'sd60, 32'd5000, 32'd10, 32'd20000};
    logic [31:0] clmp[4] = '{32'(TURNS_MIN), 32'(SPEED_MAX), 32'(RAMP_MIN), 32'(DWELL_MAX)};
    logic [31:0] prog[8] = '{32'd1, 32'd3000, 32'd2000, 32'd100, -32'sd1, 32'd600, 32'd50,
                             32'd100};

    pjs_sequencer #(.MS_CYCLES(MS)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .params_writable(!bad[0]), .main_power_on(!bad[1]), .alarm_active(bad[2]),
        .safe_state(bad[3]), .servo_on(bad[4]), .forward_travel_limit(forward_travel_limit),
        .reverse_travel_limit(rev_lim | bad[6]), .session_closed(session_closed),
        .jog_active(jog_active), .limit_override(lim_ovr), .speed_cmd(speed_cmd),
        .dir_reverse(dir_reverse), .pos_cmd(pos_cmd)
    );
    pjs_motor_model u_motor (.pclk(pclk), .presetn(presetn), .pos_cmd(pos_cmd),
        .fwd_limit(fwd_lim), .rev_limit(rev_lim));
    assign forward_travel_limit = fwd_lim | bad[5];

    always #2 pclk = ~pclk;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x, input logic [32:0] mk);
        exp_q.push_back(x & mk);
        msk_q.push_back(mk);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************
    // Monitor and timeout
    // ****************************************
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk({pslverr, prdata} & m, e);
        end
        if (jog_active === 1'b1) begin
            saw_fwd = saw_fwd | forward_travel_limit;
            if (!dir_reverse && speed_cmd > peak_a) peak_a = speed_cmd;
            if (dir_reverse && speed_cmd > peak_b) peak_b = speed_cmd;
            zrun = (speed_cmd == 12'h000) ? zrun + 1 : 0;
            if (zrun > zmax) zmax = zrun;
        end
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) rd(8'h10 + 8'(4 * i), {1'b0, dflt[i % 4]}, FULL);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h10 + 8'(4 * i), over[i]);
            rd(8'h10 + 8'(4 * i), {1'b0, clmp[i]}, FULL);
        end
        rd(8'h0c, 33'h1_0000_0000, FULL);
        rd(PJS_CTRL_OFS, 33'h0, FULL);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            v = 32'(SPEED_MIN) + 32'(rnd % 16'd2901);
            apb(1'b1, PJS_B_SPEED_OFS, v);
            rd(PJS_B_SPEED_OFS, {1'b0, v}, FULL);
        end
        for (int i = 0; i < 7; i++) begin
            bad <= 7'h01 << i;
            @(posedge pclk);
            rd(PJS_COND_OFS, 33'h0, 33'h1);
            apb(1'b1, PJS_CTRL_OFS, 32'h1);
            rd(PJS_STAT_OFS, 33'h0, 33'h1);
        end
        bad <= 7'h00;
        @(posedge pclk);
        rd(PJS_COND_OFS, 33'h1, 33'h1);
        for (int i = 0; i < 8; i++) apb(1'b1, 8'h10 + 8'(4 * i), prog[i]);
        apb(1'b1, PJS_CTRL_OFS, 32'h1);
        rd(PJS_STAT_OFS, 33'h1, 33'h3);
        // Operator energises the motor; a running sequence must not care
        bad <= 7'h10;
        while (dir_reverse !== 1'b1) @(posedge pclk);
        chk({32'h0, saw_fwd & jog_active}, 33'h1);
        chk({32'h0, lim_ovr}, 33'h1);
        chk(33'(peak_a < 12'(SPEED_MAX) && peak_a != 12'h000), 33'h1);
        chk(33'(zmax >= 99 * MS && zmax <= 104 * MS), 33'h1);
        while (dir_reverse !== 1'b0) @(posedge pclk);
        chk({21'h0, peak_b}, {21'h0, 12'd600});
        chk({9'h0, pos_cmd}, 33'h0);
        chk({32'h0, jog_active}, 33'h1);
        apb(1'b1, PJS_CTRL_OFS, 32'h2);
        chk({19'h0, lim_ovr, jog_active, speed_cmd}, 33'h0);
        rd(PJS_STAT_OFS, 33'h0, 33'h1);
        bad <= 7'h00;
        apb(1'b1, PJS_CTRL_OFS, 32'h1);
        while (speed_cmd === 12'h000) @(posedge pclk);
        session_closed <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({20'h0, jog_active, speed_cmd}, 33'h0);
        session_closed <= 1'b0;
        tally_and_finish();
    end
endmodule // pjs_sequencer_test
